// file: src/rsp_defines.svh
// Offsets, field positions, codes and reset values of the PWM timer
`ifndef RSP_DEFINES_SVH
`define RSP_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RSP_IDX_CNT0      24'hfff706
`define RSP_IDX_GRA0      24'hfff708
`define RSP_IDX_GRB0      24'hfff70a
`define RSP_IDX_GRC0      24'hfff70c
`define RSP_IDX_CNT1      24'hfff716
`define RSP_IDX_GRA1      24'hfff718
`define RSP_IDX_GRB1      24'hfff71a
`define RSP_IDX_GRC1      24'hfff71c
`define RSP_IDX_START     24'hfff720
`define RSP_IDX_MODE      24'hfff721
`define RSP_IDX_FUNC      24'hfff723
`define RSP_IDX_OUTEN     24'hfff724
`define RSP_IDX_INITLVL   24'hfff725
`define RSP_IDX_CTL0      24'hfff700
`define RSP_IDX_STAT0     24'hfff703
`define RSP_IDX_CTL1      24'hfff710
`define RSP_IDX_STAT1     24'hfff713

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define RSP_RUN_CH0       0
`define RSP_RUN_CH1       1
`define RSP_SYNC_BIT      0
`define RSP_OLS_CH0       2
`define RSP_OLS_CH1       3
`define RSP_CMD_RESET_PWM 2'h1
`define RSP_CLR_NONE      3'h0
`define RSP_CLR_ON_A      3'h1
`define RSP_FLAG_A        0
`define RSP_FLAG_C        2
`define RSP_PIN_A0        0
`define RSP_PIN_B0        1
`define RSP_PIN_C0        2
`define RSP_PIN_D0        3
`define RSP_PIN_A1        4
`define RSP_PIN_B1        5
`define RSP_PIN_C1        6
`define RSP_PIN_D1        7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RSP_RST_BYTE      8'h00
`define RSP_RST_OUTEN     8'hff
`define RSP_RST_WORD      16'h0000

`endif

// file: src/rsp_pkg.sv
// Types shared by the PWM timer design
package rsp_pkg;

    typedef enum logic [4:0] {
        RSP_R_NONE  = 5'h00,
        RSP_R_CNT0  = 5'h01,
        RSP_R_GRA0  = 5'h02,
        RSP_R_GRB0  = 5'h03,
        RSP_R_GRC0  = 5'h04,
        RSP_R_CNT1  = 5'h05,
        RSP_R_GRA1  = 5'h06,
        RSP_R_GRB1  = 5'h07,
        RSP_R_GRC1  = 5'h08,
        RSP_R_START = 5'h09,
        RSP_R_MODE  = 5'h0a,
        RSP_R_FUNC  = 5'h0b,
        RSP_R_OUTEN = 5'h0c,
        RSP_R_INIT  = 5'h0d,
        RSP_R_CTL0  = 5'h0e,
        RSP_R_CTL1  = 5'h0f,
        RSP_R_STAT0 = 5'h10,
        RSP_R_STAT1 = 5'h11
    } rsp_reg_t;

endpackage

// file: src/rsp_timer.sv
// Two-channel 16-bit timer with reset-synchronous PWM outputs, AHB-Lite
`timescale 1ns/10ps
`include "rsp_defines.svh"

module rsp_timer
    import rsp_pkg::*;
#(
    parameter int CNT_W = 16
)(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    output logic                   pwm1_normal_pin,
    output logic                   pwm1_inverse_pin,
    output logic                   pwm2_normal_pin,
    output logic                   pwm2_inverse_pin,
    output logic                   pwm3_normal_pin,
    output logic                   pwm3_inverse_pin,
    output logic                   period_sync_pin,
    output logic                   spare_a0_pin,
    output logic [7:0]             pin_drive_en,
    output logic                   channel_zero_irq,
    output logic                   channel_one_irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Counters must fit the low half of the data bus
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
        $error("rsp_timer: CNT_W must lie between 2 and 16");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic rsp_reg_t addr_decode(input logic [31:0] a);
        rsp_reg_t r;
        r = RSP_R_NONE;
        if (a[31:26] == 6'h00) begin
            case (a[25:2])
                `RSP_IDX_CNT0:    r = RSP_R_CNT0;
                `RSP_IDX_GRA0:    r = RSP_R_GRA0;
                `RSP_IDX_GRB0:    r = RSP_R_GRB0;
                `RSP_IDX_GRC0:    r = RSP_R_GRC0;
                `RSP_IDX_CNT1:    r = RSP_R_CNT1;
                `RSP_IDX_GRA1:    r = RSP_R_GRA1;
                `RSP_IDX_GRB1:    r = RSP_R_GRB1;
                `RSP_IDX_GRC1:    r = RSP_R_GRC1;
                `RSP_IDX_START:   r = RSP_R_START;
                `RSP_IDX_MODE:    r = RSP_R_MODE;
                `RSP_IDX_FUNC:    r = RSP_R_FUNC;
                `RSP_IDX_OUTEN:   r = RSP_R_OUTEN;
                `RSP_IDX_INITLVL: r = RSP_R_INIT;
                `RSP_IDX_CTL0:    r = RSP_R_CTL0;
                `RSP_IDX_CTL1:    r = RSP_R_CTL1;
                `RSP_IDX_STAT0:   r = RSP_R_STAT0;
                `RSP_IDX_STAT1:   r = RSP_R_STAT1;
                default:          r = RSP_R_NONE;
            endcase
        end
        return r;
    endfunction

    // Count-clock tick from the prescaler field; external clocks absent
    function automatic logic count_tick(input logic [2:0] psc,
                                        input logic [2:0] div);
        case (psc)
            3'h0:    return 1'b1;
            3'h1:    return div[0];
            3'h2:    return &div[1:0];
            3'h3:    return &div[2:0];
            default: return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [1:0]       start_r,   start_nxt;
    logic [7:0]       mode_r,    mode_nxt;
    logic [7:0]       func_r,    func_nxt;
    logic [7:0]       outen_r,   outen_nxt;
    logic [7:0]       init_r,    init_nxt;
    logic [7:0]       ctl0_r,    ctl0_nxt;
    logic [7:0]       ctl1_r,    ctl1_nxt;
    logic [CNT_W-1:0] cnt0_r,    cnt0_nxt;
    logic [CNT_W-1:0] cnt1_r,    cnt1_nxt;
    logic [CNT_W-1:0] gra0_r,    gra0_nxt;
    logic [CNT_W-1:0] grb0_r,    grb0_nxt;
    logic [CNT_W-1:0] grc0_r,    grc0_nxt;
    logic [CNT_W-1:0] gra1_r,    gra1_nxt;
    logic [CNT_W-1:0] grb1_r,    grb1_nxt;
    logic [CNT_W-1:0] grc1_r,    grc1_nxt;
    logic [7:0]       stat0_r,   stat0_nxt;
    logic [7:0]       stat1_r,   stat1_nxt;
    logic [7:0]       pin_r,     pin_nxt;
    logic [7:0]       pinen_r,   pinen_nxt;
    logic             irq0_r,    irq0_nxt;
    logic             irq1_r,    irq1_nxt;
    logic [2:0]       div_r,     div_nxt;
    rsp_reg_t         dsel_r,    dsel_nxt;
    logic             dwr_r,     dwr_nxt;
    logic [31:0]      rdata_r,   rdata_nxt;
    logic             rdy_r;

    // ------------------------------------------------------------
    // Compare logic
    // ------------------------------------------------------------
    logic             tick0, tick1, pwm_mode, sync_on;
    logic             m_a0, m_b0, m_c0, m_a1, m_b1, m_c1;
    logic             clr0, clr1, wr0, wr1;
    logic [CNT_W-1:0] wdat;
    logic [CNT_W-1:0] base1;

    always_comb begin
        wdat     = hwdata[CNT_W-1:0];
        pwm_mode = func_r[1:0] == `RSP_CMD_RESET_PWM;
        sync_on  = mode_r[`RSP_SYNC_BIT];
        // Matches are qualified by the tick so a stopped counter
        // cannot fire the same match again and again
        tick0 = start_r[`RSP_RUN_CH0] &&
                count_tick(ctl0_r[2:0], div_r);
        tick1 = start_r[`RSP_RUN_CH1] &&
                count_tick(ctl1_r[2:0], div_r);
        // Compare registers are always plain compares; buffer bits
        // are stored only
        m_a0 = tick0 && cnt0_r == gra0_r;
        m_b0 = tick0 && cnt0_r == grb0_r;
        m_c0 = tick0 && cnt0_r == grc0_r;
        base1 = pwm_mode ? cnt0_r : cnt1_r;
        m_a1 = (pwm_mode ? tick0 : tick1) && base1 == gra1_r;
        m_b1 = (pwm_mode ? tick0 : tick1) && base1 == grb1_r;
        m_c1 = tick1 && cnt1_r == grc1_r;
        clr0 = m_a0 && ctl0_r[7:5] == `RSP_CLR_ON_A;
        clr1 = tick1 && cnt1_r == gra1_r && !pwm_mode &&
               ctl1_r[7:5] == `RSP_CLR_ON_A;
        wr0  = dwr_r && dsel_r == RSP_R_CNT0;
        wr1  = dwr_r && dsel_r == RSP_R_CNT1;
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        rsp_reg_t asel;
        asel      = addr_decode(haddr);
        start_nxt = start_r;
        mode_nxt  = mode_r;
        func_nxt  = func_r;
        outen_nxt = outen_r;
        init_nxt  = init_r;
        ctl0_nxt  = ctl0_r;
        ctl1_nxt  = ctl1_r;
        gra0_nxt  = gra0_r;
        grb0_nxt  = grb0_r;
        grc0_nxt  = grc0_r;
        gra1_nxt  = gra1_r;
        grb1_nxt  = grb1_r;
        grc1_nxt  = grc1_r;
        pin_nxt   = pin_r;
        div_nxt   = div_r + 3'h1;

        // Counters: a bus write beats counting
        cnt0_nxt = cnt0_r;
        if (wr0 || (sync_on && wr1)) begin
            cnt0_nxt = wdat;
        end else if (tick0) begin
            cnt0_nxt = clr0 ? '0 : cnt0_r + 1'b1;
        end
        cnt1_nxt = cnt1_r;
        if (wr1 || (sync_on && wr0)) begin
            cnt1_nxt = wdat;
        end else if (sync_on && clr0) begin
            cnt1_nxt = '0;
        end else if (tick1) begin
            cnt1_nxt = clr1 ? '0 : cnt1_r + 1'b1;
        end

        // Sticky flags; a hardware set beats a write-0 clear
        stat0_nxt = stat0_r;
        stat1_nxt = stat1_r;
        if (dwr_r && dsel_r == RSP_R_STAT0) begin
            stat0_nxt = stat0_r & hwdata[7:0];
        end
        if (dwr_r && dsel_r == RSP_R_STAT1) begin
            stat1_nxt = stat1_r & hwdata[7:0];
        end
        stat0_nxt[`RSP_FLAG_A] = stat0_nxt[`RSP_FLAG_A] | m_a0;
        stat0_nxt[`RSP_FLAG_C] = stat0_nxt[`RSP_FLAG_C] | m_c0;
        stat1_nxt[`RSP_FLAG_A] = stat1_nxt[`RSP_FLAG_A] | m_a1;
        stat1_nxt[`RSP_FLAG_C] = stat1_nxt[`RSP_FLAG_C] | m_c1;
        irq0_nxt = stat0_nxt[`RSP_FLAG_A] | stat0_nxt[`RSP_FLAG_C];
        irq1_nxt = stat1_nxt[`RSP_FLAG_A] | stat1_nxt[`RSP_FLAG_C];

        // PWM waveform; the period clear wins over a duty match
        if (pwm_mode) begin
            if (m_b0) begin
                pin_nxt[`RSP_PIN_B0] = func_r[`RSP_OLS_CH0];
                pin_nxt[`RSP_PIN_D0] = !func_r[`RSP_OLS_CH1];
            end
            if (m_a1) begin
                pin_nxt[`RSP_PIN_A1] = func_r[`RSP_OLS_CH0];
                pin_nxt[`RSP_PIN_C1] = !func_r[`RSP_OLS_CH1];
            end
            if (m_b1) begin
                pin_nxt[`RSP_PIN_B1] = func_r[`RSP_OLS_CH0];
                pin_nxt[`RSP_PIN_D1] = !func_r[`RSP_OLS_CH1];
            end
            if (m_a0) begin
                pin_nxt[`RSP_PIN_B0] = !func_r[`RSP_OLS_CH0];
                pin_nxt[`RSP_PIN_A1] = !func_r[`RSP_OLS_CH0];
                pin_nxt[`RSP_PIN_B1] = !func_r[`RSP_OLS_CH0];
                pin_nxt[`RSP_PIN_D0] = func_r[`RSP_OLS_CH1];
                pin_nxt[`RSP_PIN_C1] = func_r[`RSP_OLS_CH1];
                pin_nxt[`RSP_PIN_D1] = func_r[`RSP_OLS_CH1];
            end
            if (m_c0) begin
                pin_nxt[`RSP_PIN_C0] = !pin_r[`RSP_PIN_C0];
            end
        end
        pinen_nxt = ~outen_r;

        // Register writes in the data phase
        if (dwr_r) begin
            case (dsel_r)
                RSP_R_GRA0:  gra0_nxt  = wdat;
                RSP_R_GRB0:  grb0_nxt  = wdat;
                RSP_R_GRC0:  grc0_nxt  = wdat;
                RSP_R_GRA1:  gra1_nxt  = wdat;
                RSP_R_GRB1:  grb1_nxt  = wdat;
                RSP_R_GRC1:  grc1_nxt  = wdat;
                RSP_R_START: start_nxt = hwdata[1:0];
                RSP_R_MODE:  mode_nxt  = hwdata[7:0];
                RSP_R_FUNC:  func_nxt  = hwdata[7:0];
                RSP_R_OUTEN: outen_nxt = hwdata[7:0];
                RSP_R_INIT: begin
                    init_nxt = hwdata[7:0];
                    pin_nxt  = hwdata[7:0];
                end
                RSP_R_CTL0:  ctl0_nxt  = hwdata[7:0];
                RSP_R_CTL1:  ctl1_nxt  = hwdata[7:0];
                default:     start_nxt = start_r;
            endcase
        end

        // Address phase; reads return the post-update values so a
        // read right after a write sees the new data
        dsel_nxt  = RSP_R_NONE;
        dwr_nxt   = 1'b0;
        rdata_nxt = 32'h0000_0000;
        if (hsel && htrans[1] && hready) begin
            dsel_nxt = asel;
            dwr_nxt  = hwrite;
            if (!hwrite) begin
                case (asel)
                    RSP_R_CNT0:  rdata_nxt[CNT_W-1:0] = cnt0_nxt;
                    RSP_R_GRA0:  rdata_nxt[CNT_W-1:0] = gra0_nxt;
                    RSP_R_GRB0:  rdata_nxt[CNT_W-1:0] = grb0_nxt;
                    RSP_R_GRC0:  rdata_nxt[CNT_W-1:0] = grc0_nxt;
                    RSP_R_CNT1:  rdata_nxt[CNT_W-1:0] = cnt1_nxt;
                    RSP_R_GRA1:  rdata_nxt[CNT_W-1:0] = gra1_nxt;
                    RSP_R_GRB1:  rdata_nxt[CNT_W-1:0] = grb1_nxt;
                    RSP_R_GRC1:  rdata_nxt[CNT_W-1:0] = grc1_nxt;
                    RSP_R_START: rdata_nxt[1:0] = start_nxt;
                    RSP_R_MODE:  rdata_nxt[7:0] = mode_nxt;
                    RSP_R_FUNC:  rdata_nxt[7:0] = func_nxt;
                    RSP_R_OUTEN: rdata_nxt[7:0] = outen_nxt;
                    RSP_R_INIT:  rdata_nxt[7:0] = init_nxt;
                    RSP_R_CTL0:  rdata_nxt[7:0] = ctl0_nxt;
                    RSP_R_CTL1:  rdata_nxt[7:0] = ctl1_nxt;
                    RSP_R_STAT0: rdata_nxt[7:0] = stat0_nxt;
                    RSP_R_STAT1: rdata_nxt[7:0] = stat1_nxt;
                    default:     rdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_r <= 2'h0;
            mode_r  <= `RSP_RST_BYTE;
            func_r  <= `RSP_RST_BYTE;
            outen_r <= `RSP_RST_OUTEN;
            init_r  <= `RSP_RST_BYTE;
            ctl0_r  <= `RSP_RST_BYTE;
            ctl1_r  <= `RSP_RST_BYTE;
            cnt0_r  <= '0;
            cnt1_r  <= '0;
            gra0_r  <= '1;
            grb0_r  <= '1;
            grc0_r  <= '1;
            gra1_r  <= '1;
            grb1_r  <= '1;
            grc1_r  <= '1;
            stat0_r <= `RSP_RST_BYTE;
            stat1_r <= `RSP_RST_BYTE;
            pin_r   <= `RSP_RST_BYTE;
            pinen_r <= `RSP_RST_BYTE;
            irq0_r  <= 1'b0;
            irq1_r  <= 1'b0;
            div_r   <= 3'h0;
            dsel_r  <= RSP_R_NONE;
            dwr_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rdy_r   <= 1'b1;
        end else begin
            start_r <= start_nxt;
            mode_r  <= mode_nxt;
            func_r  <= func_nxt;
            outen_r <= outen_nxt;
            init_r  <= init_nxt;
            ctl0_r  <= ctl0_nxt;
            ctl1_r  <= ctl1_nxt;
            cnt0_r  <= cnt0_nxt;
            cnt1_r  <= cnt1_nxt;
            gra0_r  <= gra0_nxt;
            grb0_r  <= grb0_nxt;
            grc0_r  <= grc0_nxt;
            gra1_r  <= gra1_nxt;
            grb1_r  <= grb1_nxt;
            grc1_r  <= grc1_nxt;
            stat0_r <= stat0_nxt;
            stat1_r <= stat1_nxt;
            pin_r   <= pin_nxt;
            pinen_r <= pinen_nxt;
            irq0_r  <= irq0_nxt;
            irq1_r  <= irq1_nxt;
            div_r   <= div_nxt;
            dsel_r  <= dsel_nxt;
            dwr_r   <= dwr_nxt;
            rdata_r <= rdata_nxt;
            rdy_r   <= 1'b1;
        end
    end

    assign hreadyout        = rdy_r;
    assign hresp            = 1'b0;
    assign hrdata           = rdata_r;
    assign pwm1_normal_pin  = pin_r[`RSP_PIN_B0];
    assign pwm1_inverse_pin = pin_r[`RSP_PIN_D0];
    assign pwm2_normal_pin  = pin_r[`RSP_PIN_A1];
    assign pwm2_inverse_pin = pin_r[`RSP_PIN_C1];
    assign pwm3_normal_pin  = pin_r[`RSP_PIN_B1];
    assign pwm3_inverse_pin = pin_r[`RSP_PIN_D1];
    assign period_sync_pin  = pin_r[`RSP_PIN_C0];
    assign spare_a0_pin     = pin_r[`RSP_PIN_A0];
    assign pin_drive_en     = pinen_r;
    assign channel_zero_irq = irq0_r;
    assign channel_one_irq  = irq1_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_period_match;
        pwm_mode && func_r[3:2] == 2'h3 && m_a0 && !dwr_r;
    endsequence

    sequence s_duty_only;
        pwm_mode && func_r[3:2] == 2'h3 && m_b0 && !m_a0 && !dwr_r;
    endsequence

    a_cnt0_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !start_r[0] && !wr0 && !(sync_on && wr1) |=> $stable(cnt0_r))
        else $error("channel 0 counter moved while stopped");

    a_cnt0_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        clr0 && !dwr_r |=> cnt0_r == '0)
        else $error("channel 0 counter not cleared on period match");

    a_cnt1_free: assert property (@(posedge hclk) disable iff (!hresetn)
        start_r[1] && ctl1_r == 8'h00 && !sync_on && !dwr_r
        |=> cnt1_r == $past(cnt1_r) + 1'b1)
        else $error("channel 1 counter did not run freely");

    a_flag_period: assert property (@(posedge hclk) disable iff (!hresetn)
        tick0 && cnt0_r == gra0_r |=> stat0_r[0] ##1 irq0_r)
        else $error("period match did not set flag and request");

    a_flag_c1: assert property (@(posedge hclk) disable iff (!hresetn)
        m_c1 |=> stat1_r[2] && channel_one_irq)
        else $error("C1 match did not set flag C of channel 1");

    a_pwm_off: assert property (@(posedge hclk) disable iff (!hresetn)
        s_period_match |=> !pwm1_normal_pin && pwm1_inverse_pin)
        else $error("pair 1 not inactive after period clear");

    a_pwm_on: assert property (@(posedge hclk) disable iff (!hresetn)
        s_duty_only |=> pwm1_normal_pin && !pwm1_inverse_pin)
        else $error("pair 1 not active after duty match");

    a_sync_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
        pwm_mode && m_c0 && !dwr_r
        |=> period_sync_pin != $past(period_sync_pin))
        else $error("period sync pin did not toggle");

    a_irq_c0: assert property (@(posedge hclk) disable iff (!hresetn)
        m_c0 |=> ##1 channel_zero_irq)
        else $error("C0 match raised no channel 0 request");

endmodule

// file: bench/rsp_loads.sv
// Load model timing PWM pulse widths and period-sync toggles
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Pulse timer on the three normal pins and the sync pin
// ----------------------------------------------------------------
module rsp_loads (
    input  wire logic        hclk,
    input  wire logic [2:0]  norm,
    input  wire logic        sync,
    output logic [15:0]      hi_w [3],
    output logic [15:0]      per_w
);
    logic [15:0] run [3] = '{default: 16'h0000};
    logic [15:0] sc = 16'h0001;
    logic        sp = 1'b0;

    initial begin
        hi_w = '{default: 16'h0000};
        per_w = 16'h0000;
    end

    // Samples land before the design's updates, so a run counts edges
    always @(posedge hclk) begin
        for (int i = 0; i < 3; i++) begin
            if (norm[i]) begin
                run[i] <= run[i] + 16'h0001;
            end else begin
                if (run[i] != 16'h0000) hi_w[i] <= run[i];
                run[i] <= 16'h0000;
            end
        end
        sp <= sync;
        sc <= (sync != sp) ? 16'h0001 : sc + 16'h0001;
        if (sync != sp) per_w <= sc;
    end
endmodule

// file: bench/tb_top.sv
// Register-level testbench of the reset-synchronous PWM timer
`timescale 1ns/10ps
`include "rsp_defines.svh"

// ----------------------------------------------------------------
// Signals and instances
// ----------------------------------------------------------------
module tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0, hreadyout, hresp, irq0, irq1, syn, spr;
    logic [7:0]  pde;
    logic [2:0]  nrm, inv;
    logic [15:0] hi_w [3];
    logic [15:0] per_w;
    logic [15:0] tbl [4] = '{16'h0006, 16'h000a, 16'h000e, 16'h0009};
    logic [23:0] ci [15] = '{`RSP_IDX_CTL0, `RSP_IDX_CTL1, `RSP_IDX_MODE,
        `RSP_IDX_FUNC, `RSP_IDX_INITLVL, `RSP_IDX_GRA0, `RSP_IDX_GRB0,
        `RSP_IDX_GRC0, `RSP_IDX_GRA1, `RSP_IDX_GRB1, `RSP_IDX_GRC1,
        `RSP_IDX_CNT0, `RSP_IDX_CNT1, `RSP_IDX_OUTEN, `RSP_IDX_START};
    logic [7:0]  cv [15] = '{8'h20, 8'h00, 8'h00, 8'h0d, 8'h00, 8'h14,
        8'h08, 8'h14, 8'h0c, 8'h0f, 8'h1e, 8'h00, 8'h00, 8'h00, 8'h03};
    int          errors = 0, checks_done = 0, k;

    always #10 hclk = ~hclk;

    rsp_timer i_rsp_timer (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pwm1_normal_pin(nrm[0]),
        .pwm1_inverse_pin(inv[0]), .pwm2_normal_pin(nrm[1]),
        .pwm2_inverse_pin(inv[1]), .pwm3_normal_pin(nrm[2]),
        .pwm3_inverse_pin(inv[2]), .period_sync_pin(syn),
        .spare_a0_pin(spr), .pin_drive_en(pde),
        .channel_zero_irq(irq0), .channel_one_irq(irq1));
    rsp_loads i_rsp_loads (.hclk(hclk), .norm(nrm), .sync(syn),
        .hi_w(hi_w), .per_w(per_w));

// ----------------------------------------------------------------
// Bus and check tasks
// ----------------------------------------------------------------
    task automatic bus(input logic w, input logic [23:0] idx,
                       input logic [31:0] wd);
        haddr <= {6'h00, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    // Bounded so a dead interrupt cannot hang the run
    task automatic wt_irq(input logic lv);
        for (k = 0; k < 100 && irq0 !== lv; k++) @(posedge hclk);
        // One more edge so the load model has taken the last pulse
        @(posedge hclk);
    endtask

    task automatic end_sim;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

// ----------------------------------------------------------------
// Tests
// ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        chk("drive_en", {24'h0, pde}, 32'h0);
        bus(1'b0, `RSP_IDX_OUTEN, 32'h0);
        chk("outen", rd, 32'hff);
        bus(1'b0, 24'h000123, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        bus(1'b1, `RSP_IDX_INITLVL, 32'h03);
        @(posedge hclk);
        chk("init_b0", {31'h0, nrm[0]}, 32'h1);
        chk("init_a0", {31'h0, spr}, 32'h1);
        for (int j = 0; j < 15; j++) bus(1'b1, ci[j], {24'h0, cv[j]});
        @(posedge hclk);
        chk("drive_on", {24'h0, pde}, 32'hff);
        chk("init_low", {29'h0, nrm}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wt_irq(1'b1);
            chk("irq0", {31'h0, irq0}, 32'h1);
            chk("inverse", {29'h0, inv}, {29'h0, ~nrm});
            chk("b0_width", {16'h0, hi_w[0]},
                {16'h0, 16'h0014 - (i > 0 ? tbl[i - 1] : 16'h0008)});
            if (i > 0) begin
                chk("period", {16'h0, per_w}, 32'h15);
                chk("a1_width", {16'h0, hi_w[1]}, 32'h08);
                chk("b1_width", {16'h0, hi_w[2]}, 32'h05);
            end
            bus(1'b0, `RSP_IDX_STAT0, 32'h0);
            chk("stat0", rd, 32'h05);
            bus(1'b1, `RSP_IDX_GRB0, {16'h0, tbl[i]});
            bus(1'b1, `RSP_IDX_STAT0, 32'h0);
            wt_irq(1'b0);
            chk("irq0_clr", {31'h0, irq0}, 32'h0);
        end
        chk("irq1", {31'h0, irq1}, 32'h1);
        bus(1'b0, `RSP_IDX_STAT1, 32'h0);
        chk("stat1_c", rd & 32'h04, 32'h04);
        bus(1'b0, `RSP_IDX_CNT1, 32'h0);
        chk("free_run", {31'h0, rd > 32'h1e}, 32'h1);
        bus(1'b1, `RSP_IDX_START, 32'h01);
        bus(1'b0, `RSP_IDX_CNT1, 32'h0);
        v = rd;
        bus(1'b0, `RSP_IDX_CNT1, 32'h0);
        chk("hold", rd, v);
        bus(1'b1, `RSP_IDX_CNT1, 32'h1234);
        bus(1'b0, `RSP_IDX_CNT1, 32'h0);
        chk("cnt1_wr", rd, 32'h1234);
        bus(1'b1, `RSP_IDX_OUTEN, 32'hff);
        repeat (2) @(posedge hclk);
        chk("drive_off", {24'h0, pde}, 32'h0);
        end_sim;
    end

    initial begin
        repeat (5000) @(posedge hclk);
        errors++;
        end_sim;
    end
endmodule
